//--- inc/power_rail_regs.svh
// Command codes, field positions, reset values and scaling constants of the rail settings
`ifndef POWER_RAIL_REGS_SVH
`define POWER_RAIL_REGS_SVH

`define CMD_LOAD_LINE 8'h28
`define CMD_SW_RATE 8'h33
`define CMD_PHASE_POS 8'h37
`define CMD_OV_LIMIT 8'h40

`define LOAD_LINE_RST 16'h0000
`define L11_EXP_MSB 15
`define L11_EXP_LSB 11
`define L11_MAN_MSB 10
`define PHASE_POS_MSB 3
`define Q8_SHIFT 8

// 40 mV/A in Q8 fixed point
`define SLOPE_MAX_Q8 32'sh0000_2800
// Q12 millivolts to output units of 2^-13 V
`define MV_Q12_TO_VOUT 34'sd500

`define REF_CLK_KHZ 15'h3e80
`define DIV_MIN 15'h000c
`define DIV_MAX 15'h0050
`define FSW_MIN_KHZ 11'h0c8
`define FSW_MAX_KHZ 11'h535

`define OV_DEF_NUM 16'h0073
`define OV_DEF_DEN 32'h0000_0064

// Phase angles are in half degrees
`define PHASE_STEP_HDEG 11'h02d
`define FULL_TURN_HDEG 11'h2d0
`define GRP_STEP_2 11'h168
`define GRP_STEP_3 11'h0f0
`define GRP_STEP_4 11'h0b4

`endif

//--- inc/power_rail_pkg.sv
// Types shared by the rail setting bank
package power_rail_pkg;

    typedef enum logic [1:0] {
        CFG_LOAD = 2'b01,
        CFG_RUN = 2'b10
    } cfg_phase_t;

    typedef struct packed {
        cfg_phase_t phase;
        logic [15:0] slope;
        logic [15:0] freq;
        logic [3:0] pos;
        logic [15:0] ov;
        logic [6:0] div_run;
        logic [15:0] rd_data;
        logic [15:0] vout_target;
        logic ov_fault;
        logic [6:0] sw_cnt;
        logic sw_tick;
        logic [10:0] offset_hdeg;
        logic [6:0] delay_ticks;
    } rail_state_t;

    typedef struct packed {
        logic unused;
    } l11_state_t;

endpackage

//--- core/linear11_decode.sv
// Converts an exponent/mantissa word into a saturated Q8 fixed-point value
`timescale 1ns/1ns
`include "power_rail_regs.svh"
module linear11_decode (
    input wire logic [15:0] word,          // Encoded value
    output logic signed [31:0] value_q8    // Mantissa times two to the exponent, Q8
);
    import power_rail_pkg::*;

    logic signed [4:0] exp_s;
    logic signed [47:0] man_w;
    logic signed [47:0] scaled;
    logic [4:0] sh;

    always_comb begin
        exp_s = signed'(word[`L11_EXP_MSB:`L11_EXP_LSB]);
        man_w = 48'(signed'(word[`L11_MAN_MSB:0])) <<< `Q8_SHIFT;
        sh = exp_s[4] ? 5'(-exp_s) : 5'(exp_s);
        if (exp_s[4]) begin
            scaled = man_w >>> sh;
        end else begin
            scaled = man_w <<< sh;
        end
        // Saturate instead of wrapping so a wild exponent cannot flip the sign
        if (scaled > 48'sh0000_7fff_ffff) begin
            value_q8 = 32'sh7fff_ffff;
        end else if (scaled < -48'sh0000_8000_0000) begin
            value_q8 = -32'sh7fff_ffff - 32'sd1;
        end else begin
            value_q8 = scaled[31:0];
        end
    end

endmodule

//--- core/power_rail_config_regs.sv
// Rail configuration bank: load line, switching rate, phase position and overvoltage limit
`timescale 1ns/1ns
`include "power_rail_regs.svh"
// Overview of operation
// - Load-line and rate words decode as signed mantissa 10:0 times two to the signed exponent 15:11.
// - Load-line slope resets to zero, meaning no droop, in millivolts per ampere.
// - Setpoint drops with output current by the slope, limited to 40 mV/A.
// - Negative (sunk) current raises the setpoint instead of lowering it.
// - Droop uses the summed current of all participating phases.
// - Switching rate is 16 MHz divided by an integer from 12 to 80.
// - Rate word loads from strap at power-up; host writes override it; 200 kHz-1.33 MHz.
// - Phase position uses bits 3:0; bits 15:4 read as zero.
// - Position zero means sixteen; each step is 22.5 degrees.
// - Position defaults to the low four bits of the strapped bus address.
// - Inside one sharing group offsets are automatic; position spaces devices/groups.
// - Phase offset is referenced to the centre of fourth output pulses.
// - Overvoltage limit is unsigned 16 bits times 2^-13 volts, up to 7.99 V.
// - Overvoltage limit defaults to 1.15 times the strapped setpoint.
// - All four words are two-byte read/write and obey write protection.
module power_rail_config_regs (
    input wire logic mclk,                           // Core clock, 10 MHz
    input wire logic arst_n,                         // Asynchronous reset, active low
    input wire logic [7:0] cmd_code,                 // Command code of the access
    input wire logic cmd_wr,                         // Word write strobe
    input wire logic cmd_rd,                         // Word read strobe
    input wire logic [15:0] cmd_wdata,               // Write data word
    output logic [15:0] cmd_rdata,                   // Read data, valid after cmd_rd
    output logic cmd_hit,                            // Command code belongs to this bank
    input wire logic write_protect,                  // Blocks all writes while high
    input wire logic [15:0] strap_sw_rate,           // Strapped rate word
    input wire logic [6:0] strap_bus_addr,           // Strapped bus address
    input wire logic [15:0] strap_vout_set,          // Strapped setpoint, 2^-13 V
    input wire logic [15:0] output_voltage_setpoint, // Present setpoint, 2^-13 V
    input wire logic output_enabled,                 // Regulated output is on
    input wire logic [7:0][15:0] phase_current,      // Signed phase currents, 1/16 A
    input wire logic [7:0] phase_active,             // Phases that share this rail
    input wire logic [1:0] share_group_size,         // Devices in sharing group minus one
    input wire logic [1:0] share_member_idx,         // This device's slot in its group
    input wire logic ref_tick,                       // One-cycle pulse per reference period
    input wire logic [15:0] vout_measured,           // Measured output, 2^-13 V
    output logic [15:0] vout_target,                 // Setpoint after droop
    output logic [6:0] sw_divisor,                   // Reference divisor in use
    output logic sw_cycle_tick,                      // One pulse per switching cycle
    output logic [10:0] phase_offset_hdeg,           // Phase offset, half degrees
    output logic [6:0] fourth_pulse_delay,           // Reference ticks to pulse centre
    output logic ov_fault                            // Output overvoltage
);
    import power_rail_pkg::*;

    rail_state_t st_r;
    rail_state_t st_nxt;

    logic signed [31:0] slope_q8;
    logic signed [31:0] freq_q8;
    logic signed [15:0] cur_masked [8];
    logic signed [18:0] cur_sum;
    logic [14:0] slope_eff;
    logic signed [33:0] prod;
    logic signed [33:0] adj;
    logic signed [34:0] target_w;
    logic [10:0] f_khz;
    logic [14:0] n_raw;
    logic [6:0] div_calc;
    logic [31:0] ov_def_w;
    logic [15:0] ov_default;
    logic [10:0] grp_step;
    logic [10:0] auto_off;
    logic [10:0] pos_off;
    logic [10:0] off_sum;
    logic [10:0] off_mod;
    logic [17:0] delay_w;
    logic wr_ok;

    linear11_decode u_slope_dec (
        .word(st_r.slope),
        .value_q8(slope_q8)
    );

    linear11_decode u_rate_dec (
        .word(st_r.freq),
        .value_q8(freq_q8)
    );

    // Inactive phases must not pull the shared load line
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_phase
            assign cur_masked[g] = phase_active[g] ? signed'(phase_current[g]) : 16'sh0000;
        end
    endgenerate

    always_comb begin
        cur_sum = 19'sh00000;
        for (int i = 0; i < 8; i++) begin
            cur_sum = cur_sum + 19'(cur_masked[i]);
        end
        // Negative slopes are treated as none; the upper end is capped
        if (slope_q8 < 32'sh0) begin
            slope_eff = 15'h0000;
        end else if (slope_q8 > `SLOPE_MAX_Q8) begin
            slope_eff = 15'(`SLOPE_MAX_Q8);
        end else begin
            slope_eff = slope_q8[14:0];
        end
        prod = signed'({1'b0, slope_eff}) * cur_sum;
        adj = prod / `MV_Q12_TO_VOUT;
        // Signed product: sunk current gives a negative adjustment and raises the target
        target_w = 35'(signed'({1'b0, output_voltage_setpoint})) - 35'(adj);
        // Frequency word is in kHz; clip to the supported span
        if (freq_q8 < 32'(signed'({1'b0, `FSW_MIN_KHZ, 8'h00}))) begin
            f_khz = `FSW_MIN_KHZ;
        end else if (freq_q8 > 32'(signed'({1'b0, `FSW_MAX_KHZ, 8'hff}))) begin
            f_khz = `FSW_MAX_KHZ;
        end else begin
            f_khz = freq_q8[18:8];
        end
        n_raw = (`REF_CLK_KHZ + 15'(f_khz >> 1)) / 15'(f_khz);
        if (n_raw < `DIV_MIN) begin
            div_calc = 7'(`DIV_MIN);
        end else if (n_raw > `DIV_MAX) begin
            div_calc = 7'(`DIV_MAX);
        end else begin
            div_calc = n_raw[6:0];
        end
        ov_def_w = (32'(strap_vout_set) * 32'(`OV_DEF_NUM)) / `OV_DEF_DEN;
        ov_default = (ov_def_w > 32'h0000_ffff) ? 16'hffff : ov_def_w[15:0];
        case (share_group_size)
            2'h1: grp_step = `GRP_STEP_2;
            2'h2: grp_step = `GRP_STEP_3;
            2'h3: grp_step = `GRP_STEP_4;
            default: grp_step = 11'h000;
        endcase
        auto_off = 11'(grp_step * 11'(share_member_idx));
        // Code zero is the sixteenth slot
        pos_off = (st_r.pos == 4'h0) ? `FULL_TURN_HDEG
                                    : 11'(`PHASE_STEP_HDEG * 11'(st_r.pos));
        off_sum = 11'(pos_off + auto_off);
        off_mod = (off_sum >= `FULL_TURN_HDEG) ? 11'(off_sum - `FULL_TURN_HDEG) : off_sum;
        delay_w = (18'(off_mod) * 18'(st_r.div_run)) / 18'(`FULL_TURN_HDEG);
    end

    assign wr_ok = cmd_wr && !write_protect && (st_r.phase == CFG_RUN);

    always_comb begin
        cmd_hit = (cmd_code == `CMD_LOAD_LINE) || (cmd_code == `CMD_SW_RATE)
               || (cmd_code == `CMD_PHASE_POS) || (cmd_code == `CMD_OV_LIMIT);
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.sw_tick = 1'b0;
        case (st_r.phase)
            CFG_LOAD: begin
                // Straps are caught on the first edge after reset release
                st_nxt.freq = strap_sw_rate;
                st_nxt.pos = strap_bus_addr[`PHASE_POS_MSB:0];
                st_nxt.ov = ov_default;
                st_nxt.phase = CFG_RUN;
            end
            CFG_RUN: begin
                if (wr_ok) begin
                    case (cmd_code)
                        `CMD_LOAD_LINE: st_nxt.slope = cmd_wdata;
                        `CMD_SW_RATE: st_nxt.freq = cmd_wdata;
                        `CMD_PHASE_POS: st_nxt.pos = cmd_wdata[`PHASE_POS_MSB:0];
                        `CMD_OV_LIMIT: st_nxt.ov = cmd_wdata;
                        default: st_nxt.ov = st_r.ov;
                    endcase
                end
            end
            default: st_nxt.phase = CFG_LOAD;
        endcase
        if (cmd_rd) begin
            case (cmd_code)
                `CMD_LOAD_LINE: st_nxt.rd_data = st_r.slope;
                `CMD_SW_RATE: st_nxt.rd_data = st_r.freq;
                `CMD_PHASE_POS: st_nxt.rd_data = {12'h000, st_r.pos};
                `CMD_OV_LIMIT: st_nxt.rd_data = st_r.ov;
                default: st_nxt.rd_data = 16'h0000;
            endcase
        end
        // A running converter keeps its divisor; a new rate takes effect once disabled
        if (!output_enabled) begin
            st_nxt.div_run = div_calc;
        end
        if (ref_tick) begin
            if (st_r.sw_cnt >= 7'(st_r.div_run - 7'h01)) begin
                st_nxt.sw_cnt = 7'h00;
                st_nxt.sw_tick = 1'b1;
            end else begin
                st_nxt.sw_cnt = 7'(st_r.sw_cnt + 7'h01);
            end
        end
        if (target_w < 35'sh0) begin
            st_nxt.vout_target = 16'h0000;
        end else if (target_w > 35'sh0_0000_ffff) begin
            st_nxt.vout_target = 16'hffff;
        end else begin
            st_nxt.vout_target = target_w[15:0];
        end
        st_nxt.ov_fault = (vout_measured > st_r.ov);
        st_nxt.offset_hdeg = off_sum;
        st_nxt.delay_ticks = delay_w[6:0];
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{phase: CFG_LOAD, slope: `LOAD_LINE_RST, div_run: 7'h50, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmd_rdata = st_r.rd_data;
    assign vout_target = st_r.vout_target;
    assign sw_divisor = st_r.div_run;
    assign sw_cycle_tick = st_r.sw_tick;
    assign phase_offset_hdeg = st_r.offset_hdeg;
    assign fourth_pulse_delay = st_r.delay_ticks;
    assign ov_fault = st_r.ov_fault;

    a_slope_reset: assert property (@(posedge mclk) $rose(arst_n) |-> st_r.slope == 16'h0000)
        else $error("load-line slope not zero after reset");

    a_decode_word: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.slope == 16'hf802 |-> slope_q8 == 32'sh0000_0100)
        else $error("exponent/mantissa decode wrong");

    a_slope_capped: assert property (@(posedge mclk) disable iff (!arst_n)
        slope_eff <= 15'h2800)
        else $error("load-line slope above limit");

    a_sink_raises: assert property (@(posedge mclk) disable iff (!arst_n)
        (cur_sum < 19'sh0 && slope_eff > 15'h0 && output_voltage_setpoint < 16'h8000)
        |=> vout_target >= $past(output_voltage_setpoint))
        else $error("sunk current lowered the setpoint");

    a_no_phases: assert property (@(posedge mclk) disable iff (!arst_n)
        phase_active == 8'h00 |=> vout_target == $past(output_voltage_setpoint))
        else $error("droop applied with no active phase");

    a_divisor_span: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.phase == CFG_RUN |-> sw_divisor >= 7'd12 && sw_divisor <= 7'd80)
        else $error("divisor outside 12..80");

    a_strap_load: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.phase == CFG_LOAD |=> st_r.pos == $past(strap_bus_addr[3:0])
        && st_r.freq == $past(strap_sw_rate))
        else $error("strap values not loaded");

    a_rate_override: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr_ok && cmd_code == 8'h33) |=> st_r.freq == $past(cmd_wdata))
        else $error("rate write lost");

    a_pos_upper_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        (cmd_rd && cmd_code == 8'h37) |=> cmd_rdata[15:4] == 12'h000)
        else $error("position upper bits not zero");

    a_pos_sixteen: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_r.pos == 4'h0 && share_group_size == 2'h0) |=> phase_offset_hdeg == 11'd720)
        else $error("position zero not sixteenth slot");

    a_protect_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_r.phase == CFG_RUN && cmd_wr && write_protect) |=> $stable(st_r.slope)
        && $stable(st_r.freq) && $stable(st_r.pos) && $stable(st_r.ov))
        else $error("protected write changed a register");

    a_ov_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        (vout_measured > st_r.ov) |=> ov_fault)
        else $error("overvoltage not flagged");

    a_ov_clear: assert property (@(posedge mclk) disable iff (!arst_n)
        (vout_measured <= st_r.ov) |=> !ov_fault)
        else $error("overvoltage flagged below the limit");

    a_slope_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr_ok && cmd_code == 8'h28) |=> st_r.slope == $past(cmd_wdata))
        else $error("load-line write lost");

    a_pos_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr_ok && cmd_code == 8'h37) |=> st_r.pos == $past(cmd_wdata[3:0]))
        else $error("position write lost");

    a_ov_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr_ok && cmd_code == 8'h40) |=> st_r.ov == $past(cmd_wdata))
        else $error("overvoltage limit write lost");

    a_ov_default: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_r.phase == CFG_LOAD && strap_vout_set < 16'hde00)
        |=> 32'(st_r.ov) * 32'd100 <= 32'($past(strap_vout_set)) * 32'd115
        && 32'(st_r.ov) * 32'd100 + 32'd100 > 32'($past(strap_vout_set)) * 32'd115)
        else $error("overvoltage default not 1.15 times strapped setpoint");

    a_slope_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (cmd_rd && cmd_code == 8'h28) |=> cmd_rdata == $past(st_r.slope))
        else $error("load-line read wrong");

    a_rate_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (cmd_rd && cmd_code == 8'h33) |=> cmd_rdata == $past(st_r.freq))
        else $error("rate read wrong");

    a_unknown_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (cmd_rd && !cmd_hit) |=> cmd_rdata == 16'h0000)
        else $error("unknown command read not zero");

    a_hit_decode: assert property (@(posedge mclk) disable iff (!arst_n)
        cmd_hit == (cmd_code inside {8'h28, 8'h33, 8'h37, 8'h40}))
        else $error("command hit wrong");

    a_rate_frozen: assert property (@(posedge mclk) disable iff (!arst_n)
        output_enabled |=> $stable(sw_divisor))
        else $error("divisor changed while output enabled");

    a_tick_at_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
        sw_cycle_tick |-> st_r.sw_cnt == 7'h00)
        else $error("switching tick away from count wrap");

    a_tick_single: assert property (@(posedge mclk) disable iff (!arst_n)
        sw_cycle_tick |=> !sw_cycle_tick)
        else $error("switching tick longer than one cycle");

    a_load_once: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.phase == CFG_RUN |=> st_r.phase == CFG_RUN)
        else $error("straps reloaded without reset");

    a_no_droop: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.slope == 16'h0000 |=> vout_target == $past(output_voltage_setpoint))
        else $error("droop applied with zero slope");

    a_droop_lowers: assert property (@(posedge mclk) disable iff (!arst_n)
        (cur_sum > 19'sh0 && slope_eff > 15'h0)
        |=> vout_target <= $past(output_voltage_setpoint))
        else $error("sourced current raised the setpoint");

    a_pos_offset: assert property (@(posedge mclk) disable iff (!arst_n)
        (share_group_size == 2'h0 && st_r.pos != 4'h0)
        |=> phase_offset_hdeg == 11'($past(st_r.pos)) * 11'd45)
        else $error("position offset not 22.5 degrees per step");

    a_delay_below: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.phase == CFG_RUN |=> fourth_pulse_delay < $past(sw_divisor))
        else $error("pulse delay not inside one switching cycle");

endmodule

//--- dv/host_model.sv
// Host side of the command port: issues whole word writes and reads
`timescale 1ns/1ns
module host_model (
    input wire logic mclk,             // Core clock
    input wire logic output_enabled,   // Regulated output is on
    input wire logic [15:0] cmd_rdata, // Read word from the bank
    output logic [7:0] cmd_code,       // Command code
    output logic cmd_wr,               // Write strobe
    output logic cmd_rd,               // Read strobe
    output logic [15:0] cmd_wdata      // Write word
);
    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = 16'h5a5a;
    end

    // One-cycle strobe launched on a falling edge; data flips after release
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        // Rate word is never sent while the output runs
        if (code == 8'h33 && output_enabled === 1'b1) begin
            return;
        end
        @(negedge mclk);
        cmd_code = code;
        cmd_wdata = data;
        cmd_wr = 1'b1;
        @(negedge mclk);
        cmd_wr = 1'b0;
        cmd_wdata = ~data;
    endtask

    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        @(negedge mclk);
        cmd_code = code;
        cmd_rd = 1'b1;
        @(negedge mclk);
        cmd_rd = 1'b0;
        data = cmd_rdata;
    endtask
endmodule

//--- dv/power_rail_config_regs_tb.sv
// Self-checking bench of the rail configuration bank
`timescale 1ns/1ns
module power_rail_config_regs_tb;
    typedef struct {logic [7:0] code; logic [15:0] wdata; logic [15:0] rexp;} row_t;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    wire logic [7:0] cmd_code;
    wire logic cmd_wr;
    wire logic cmd_rd;
    wire logic [15:0] cmd_wdata;
    logic [15:0] cmd_rdata;
    logic cmd_hit;
    logic write_protect = 1'b0;
    logic output_enabled = 1'b0;
    logic [7:0][15:0] phase_current = '0;
    logic [7:0] phase_active = 8'h00;
    logic [1:0] share_group_size = 2'h0;
    logic [1:0] share_member_idx = 2'h0;
    logic [15:0] vout_measured = 16'h0000;
    logic [15:0] vout_target;
    logic [6:0] sw_divisor;
    logic sw_cycle_tick;
    logic [10:0] phase_offset_hdeg;
    logic [6:0] fourth_pulse_delay;
    logic ov_fault;
    int num_errors = 0;
    int checks = 0;
    logic [15:0] d;
    int n;
    row_t rows [5] = '{
        '{8'h28, 16'h0001, 16'h0001},
        '{8'h37, 16'hfff4, 16'h0004},
        '{8'h40, 16'h3000, 16'h3000},
        '{8'h33, 16'h03e8, 16'h03e8},
        '{8'h51, 16'hffff, 16'h0000}};

    always #50 mclk = ~mclk;

    host_model i_host (.mclk(mclk), .output_enabled(output_enabled), .cmd_rdata(cmd_rdata),
        .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata));

    // Straps: rate 400 kHz, address low bits b, setpoint 1 V; ref tick always on
    power_rail_config_regs i_dut (.mclk(mclk), .arst_n(arst_n), .cmd_code(cmd_code),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_hit(cmd_hit), .write_protect(write_protect), .strap_sw_rate(16'h0190),
        .strap_bus_addr(7'h2b), .strap_vout_set(16'h2000),
        .output_voltage_setpoint(16'h2000), .output_enabled(output_enabled),
        .phase_current(phase_current), .phase_active(phase_active),
        .share_group_size(share_group_size), .share_member_idx(share_member_idx),
        .ref_tick(1'b1), .vout_measured(vout_measured), .vout_target(vout_target),
        .sw_divisor(sw_divisor), .sw_cycle_tick(sw_cycle_tick),
        .phase_offset_hdeg(phase_offset_hdeg), .fourth_pulse_delay(fourth_pulse_delay),
        .ov_fault(ov_fault));

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (4) @(negedge mclk);
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 100);
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (12) @(negedge mclk);
        arst_n = 1'b1;
        settle();
        i_host.rd(8'h28, d); chk16(d, 16'h0000);
        i_host.rd(8'h33, d); chk16(d, 16'h0190);
        i_host.rd(8'h37, d); chk16(d, 16'h000b);
        i_host.rd(8'h40, d); chk16(d, 16'h24cc);
        chk16({15'h0, cmd_hit}, 16'h0001);
        chk16({9'h0, sw_divisor}, 16'd40);
        chk16({5'h0, phase_offset_hdeg}, 16'd495);
        foreach (rows[i]) begin
            i_host.wr(rows[i].code, rows[i].wdata);
            i_host.rd(rows[i].code, d);
            chk16(d, rows[i].rexp);
        end
        chk16({15'h0, cmd_hit}, 16'h0000);
        settle();
        chk16({9'h0, sw_divisor}, 16'd16);
        chk16({5'h0, phase_offset_hdeg}, 16'd180);
        chk16({9'h0, fourth_pulse_delay}, 16'd4);
        // Spacing between switching pulses equals the divisor with ref tick on
        n = 0;
        while (sw_cycle_tick !== 1'b1 && n < 200) begin @(negedge mclk); n++; end
        n = 0;
        do begin @(negedge mclk); n++; end while (sw_cycle_tick !== 1'b1 && n < 200);
        chk16(n[15:0], 16'd16);
        write_protect = 1'b1;
        i_host.wr(8'h28, 16'h00ff);
        i_host.rd(8'h28, d); chk16(d, 16'h0001);
        write_protect = 1'b0;
        // 125 A over two active phases at 1 mV/A is 1024 units; phase 2 is idle
        phase_active = 8'h03;
        phase_current[0] = 16'd1000;
        phase_current[1] = 16'd1000;
        phase_current[2] = 16'h7fff;
        settle(); chk16(vout_target, 16'h1c00);
        i_host.wr(8'h28, 16'hf802);
        settle(); chk16(vout_target, 16'h1c00);
        phase_current[0] = 16'hfc18;
        phase_current[1] = 16'hfc18;
        settle(); chk16(vout_target, 16'h2400);
        // 50 mV/A is held at 40 mV/A: 12.5 A gives 500 mV
        phase_current[0] = 16'd100;
        phase_current[1] = 16'd100;
        i_host.wr(8'h28, 16'h0032);
        settle(); chk16(vout_target, 16'h1000);
        i_host.wr(8'h28, 16'h0000);
        settle(); chk16(vout_target, 16'h2000);
        i_host.wr(8'h33, 16'h087d);
        settle(); chk16({9'h0, sw_divisor}, 16'd64);
        i_host.wr(8'h33, 16'h0064);
        settle(); chk16({9'h0, sw_divisor}, 16'd80);
        vout_measured = 16'h3000;
        settle(); chk16({15'h0, ov_fault}, 16'h0000);
        vout_measured = 16'h3001;
        settle(); chk16({15'h0, ov_fault}, 16'h0001);
        share_group_size = 2'h1;
        share_member_idx = 2'h1;
        settle(); chk16({5'h0, phase_offset_hdeg}, 16'd540);
        chk16({9'h0, fourth_pulse_delay}, 16'd60);
        share_group_size = 2'h0;
        share_member_idx = 2'h0;
        i_host.wr(8'h37, 16'h0000);
        settle(); chk16({5'h0, phase_offset_hdeg}, 16'd720);
        chk16({9'h0, fourth_pulse_delay}, 16'd0);
        // A rate stored just before enabling must wait for the next disable
        i_host.wr(8'h33, 16'h03e8);
        output_enabled = 1'b1;
        settle(); chk16({9'h0, sw_divisor}, 16'd80);
        output_enabled = 1'b0;
        settle(); chk16({9'h0, sw_divisor}, 16'd16);
        // Reset in mid-run brings back the strap defaults and the zero load-line slope over host writes
        i_host.wr(8'h28, 16'h0001);
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        settle();
        chk16({9'h0, sw_divisor}, 16'd40);
        i_host.rd(8'h37, d); chk16(d, 16'h000b);
        i_host.rd(8'h40, d); chk16(d, 16'h24cc);
        i_host.rd(8'h28, d); chk16(d, 16'h0000);
        end_of_test();
    end
endmodule
